// File: logic/watchdog_timer.sv
// Watchdog timer with keyed enable, APB registers and interrupt
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "wdt_params.svh"
module watchdog_timer (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire wdt_pkg::apb_req_t apb_req_i,
  output logic                  pready_o,
  output logic [31:0]           prdata_o,
  output logic                  pslverr_o,
  input  wire wdt_pkg::core_cmd_t core_cmd_i,
  input  wire logic             low_speed_crystal_osc_i,
  input  wire logic             low_speed_internal_rc_osc_i,
  input  wire logic             external_reset_pin_n_i,
  output logic                  mcu_reset_o,
  output logic                  pc_sp_clear_o,
  output logic                  timeout_status_flag_o,
  output logic                  power_down_flag_o,
  output logic                  irq_o
);
  import wdt_pkg::*;

  // Last counter value before overflow for each period code
  function automatic logic [`CNT_W-1:0] period_last(input logic [2:0] sel);
    logic [`CNT_W-1:0] v;
    v = `LAST_2P8;
    unique case (sel)
      3'h0: v = `LAST_2P8;
      3'h1: v = `LAST_2P10;
      3'h2: v = `LAST_2P12;
      3'h3: v = `LAST_2P14;
      3'h4: v = `LAST_2P15;
      3'h5: v = `LAST_2P16;
      3'h6: v = `LAST_2P17;
      3'h7: v = `LAST_2P18;
    endcase
    return v;
  endfunction

  logic [7:0]        wdt_ctrl_r;
  logic              key_flag_r;
  logic              fss_r;
  logic              to_r;
  logic              pdf_r;
  logic [`IRQ_W-1:0] irq_stat_r;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic [`CNT_W-1:0] cnt_r;
  key_state_t        key_state_r;
  logic              lxt_d_r;
  logic              low_speed_internal_rc_osc_d_r;
  logic              pready_r;
  logic [31:0]       prdata_r;
  logic              pslverr_r;
  logic              mcu_reset_r;
  logic              pc_sp_clear_r;
  logic              irq_r;

  logic [4:0] key;
  logic       key_legal;
  logic       wdt_en;
  logic       low_speed_internal_rc_osc_tick;
  logic       wd_tick;
  logic       overflow;
  logic       key_fire;
  logic       cnt_clear;
  logic       access;
  logic       wr_take;
  logic       rd_load;
  logic       addr_ok;
  logic       clr_cmd;
  logic       halt_cmd;
  logic       sleep;

  // Decode of key, clock ticks and bus phases
  assign key       = wdt_ctrl_r[`KEY_MSB:`KEY_LSB];
  assign key_legal = (key == `KEY_ENABLE) || (key == `KEY_DISABLE);
  assign wdt_en    = (key == `KEY_ENABLE);
  assign low_speed_internal_rc_osc_tick = low_speed_internal_rc_osc_i & ~low_speed_internal_rc_osc_d_r;
  assign wd_tick   = fss_r ? (low_speed_crystal_osc_i & ~lxt_d_r) : low_speed_internal_rc_osc_tick;
  assign overflow  = wd_tick && wdt_en && (cnt_r == period_last(wdt_ctrl_r[`PER_MSB:`PER_LSB]));
  assign key_fire  = (key_state_r == KEY_W3) && low_speed_internal_rc_osc_tick;
  assign clr_cmd   = core_cmd_i.clear_watchdog_instruction;
  assign halt_cmd  = core_cmd_i.halt_instruction;
  assign sleep     = core_cmd_i.sleep_idle_mode;
  assign cnt_clear = key_fire || clr_cmd || halt_cmd || !external_reset_pin_n_i;
  assign access    = apb_req_i.psel && apb_req_i.penable;
  assign wr_take   = access && pready_r && apb_req_i.pwrite;
  assign rd_load   = access && !pready_r;
  assign addr_ok   = (apb_req_i.paddr == `WDT_CTRL_OFS) || (apb_req_i.paddr == `RST_FLAG_OFS) ||
                     (apb_req_i.paddr == `SYS_CLK_OFS) || (apb_req_i.paddr == `CORE_STAT_OFS) ||
                     (apb_req_i.paddr == `IRQ_STAT_OFS) || (apb_req_i.paddr == `IRQ_MASK_OFS);

  // Previous levels of the slow clocks for edge detection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lxt_d_r  <= 1'b0;
      low_speed_internal_rc_osc_d_r <= 1'b0;
    end else begin
      lxt_d_r  <= low_speed_crystal_osc_i;
      low_speed_internal_rc_osc_d_r <= low_speed_internal_rc_osc_i;
    end
  end

  // Divider counter, counting only while enabled
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= '0;
    end else if (cnt_clear) begin
      cnt_r <= '0;
    end else if (overflow) begin
      cnt_r <= '0;
    end else if (wd_tick && wdt_en) begin
      cnt_r <= cnt_r + `CNT_W'(1);
    end
  end

  // Delay from a bad key to the reset: three RC edges, i.e. 2 to 3 RC periods
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_state_r <= KEY_OK;
    end else begin
      unique case (key_state_r)
        KEY_OK: if (!key_legal) key_state_r <= KEY_W1;
        KEY_W1: if (low_speed_internal_rc_osc_tick) key_state_r <= KEY_W2;
        KEY_W2: if (low_speed_internal_rc_osc_tick) key_state_r <= KEY_W3;
        KEY_W3: if (low_speed_internal_rc_osc_tick) key_state_r <= KEY_OK;
      endcase
    end
  end

  // Control register; reloaded to its power-on value by the key reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wdt_ctrl_r <= `WDT_CTRL_POR;
    end else if (key_fire) begin
      wdt_ctrl_r <= `WDT_CTRL_POR;
    end else if (wr_take && apb_req_i.paddr == `WDT_CTRL_OFS) begin
      wdt_ctrl_r <= apb_req_i.pwdata[7:0];
    end
  end

  // Key corruption flag: set wins, only a written 0 clears
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_flag_r <= 1'b0;
    end else if (key_fire) begin
      key_flag_r <= 1'b1;
    end else if (wr_take && apb_req_i.paddr == `RST_FLAG_OFS && !apb_req_i.pwdata[`KEYFLAG_BIT]) begin
      key_flag_r <= 1'b0;
    end
  end

  // Slow clock source select
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fss_r <= 1'b0;
    end else if (wr_take && apb_req_i.paddr == `SYS_CLK_OFS) begin
      fss_r <= apb_req_i.pwdata[`FSS_BIT];
    end
  end

  // Time-out and power-down flags; an overflow beats a halt
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      to_r  <= 1'b0;
      pdf_r <= 1'b0;
    end else begin
      if (overflow) begin
        to_r <= 1'b1;
      end else if (halt_cmd) begin
        to_r <= 1'b0;
      end
      if (halt_cmd) begin
        pdf_r <= 1'b1;
      end else if (clr_cmd) begin
        pdf_r <= 1'b0;
      end
    end
  end

  // Reset pulses towards the core
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mcu_reset_r   <= 1'b0;
      pc_sp_clear_r <= 1'b0;
    end else begin
      mcu_reset_r   <= (overflow && !sleep) || key_fire;
      pc_sp_clear_r <= overflow && sleep;
    end
  end

  // Interrupt status (write one to clear, set wins), mask and output
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r[`IRQ_TO_BIT] <= overflow ||
        (irq_stat_r[`IRQ_TO_BIT] && !(wr_take && apb_req_i.paddr == `IRQ_STAT_OFS &&
                                      apb_req_i.pwdata[`IRQ_TO_BIT]));
      irq_stat_r[`IRQ_KEY_BIT] <= key_fire ||
        (irq_stat_r[`IRQ_KEY_BIT] && !(wr_take && apb_req_i.paddr == `IRQ_STAT_OFS &&
                                       apb_req_i.pwdata[`IRQ_KEY_BIT]));
      if (wr_take && apb_req_i.paddr == `IRQ_MASK_OFS) begin
        irq_mask_r <= apb_req_i.pwdata[`IRQ_W-1:0];
      end
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // APB slave: one wait state, read data and error loaded with pready
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= rd_load;
      pslverr_r <= rd_load && !addr_ok;
      if (rd_load) begin
        prdata_r <= '0;
        if (!apb_req_i.pwrite) begin
          unique case (apb_req_i.paddr)
            `WDT_CTRL_OFS:  prdata_r[7:0] <= wdt_ctrl_r;
            `RST_FLAG_OFS:  prdata_r[`KEYFLAG_BIT] <= key_flag_r;
            `SYS_CLK_OFS:   prdata_r[`FSS_BIT] <= fss_r;
            `CORE_STAT_OFS: prdata_r[`PDF_BIT:`TO_BIT] <= {pdf_r, to_r};
            `IRQ_STAT_OFS:  prdata_r[`IRQ_W-1:0] <= irq_stat_r;
            `IRQ_MASK_OFS:  prdata_r[`IRQ_W-1:0] <= irq_mask_r;
            default:        prdata_r <= '0;
          endcase
        end
      end
    end
  end

  assign pready_o              = pready_r;
  assign prdata_o              = prdata_r;
  assign pslverr_o             = pslverr_r;
  assign mcu_reset_o           = mcu_reset_r;
  assign pc_sp_clear_o         = pc_sp_clear_r;
  assign timeout_status_flag_o = to_r;
  assign power_down_flag_o     = pdf_r;
  assign irq_o                 = irq_r;

  // Checks on timer, key delay, flags and bus
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  bad_key_detect_a: assert property ((key_state_r == KEY_OK) && !key_legal |=> key_state_r == KEY_W1)
    else $error("bad key did not start the delay");
  key_reset_fire_a: assert property ((key_state_r == KEY_W3) && low_speed_internal_rc_osc_tick |=> mcu_reset_o && key_flag_r && cnt_r == '0)
    else $error("key reset not issued after delay");
  key_flag_set_a: assert property (key_fire |=> key_flag_r)
    else $error("key corruption flag not set");
  key_flag_hold_a: assert property (key_flag_r && !(wr_take && apb_req_i.paddr == `RST_FLAG_OFS) |=> key_flag_r)
    else $error("key corruption flag lost without write");
  flag_upper_zero_a: assert property (pready_o && $past(apb_req_i.paddr) == `RST_FLAG_OFS |-> prdata_o[7:3] == 5'h00)
    else $error("reset flag upper bits not zero");
  normal_overflow_a: assert property (overflow && !sleep |=> mcu_reset_o && !pc_sp_clear_o && timeout_status_flag_o)
    else $error("normal overflow did not reset device");
  sleep_overflow_a: assert property (overflow && sleep |=> pc_sp_clear_o && !mcu_reset_o && timeout_status_flag_o)
    else $error("sleep overflow wrong reset");
  counter_clear_a: assert property (clr_cmd || halt_cmd || !external_reset_pin_n_i |=> cnt_r == '0)
    else $error("counter not cleared");
  disabled_stop_a: assert property ((key == `KEY_DISABLE) && !cnt_clear |=> $stable(cnt_r))
    else $error("disabled watchdog counted");
  halt_flags_a: assert property (halt_cmd && !overflow |=> power_down_flag_o && !timeout_status_flag_o)
    else $error("halt flags wrong");
  period_tap_a: assert property (wd_tick && wdt_en && cnt_r == `LAST_2P8 &&
                                 wdt_ctrl_r[`PER_MSB:`PER_LSB] == 3'h0 |=> timeout_status_flag_o)
    else $error("shortest period tap missed");

  // Checks on control register, counter steps, flag clears and bus handshake
  ctrl_reload_a: assert property (key_fire |=> wdt_ctrl_r == `WDT_CTRL_POR)
    else $error("control not reloaded after key reset");
  ctrl_hold_a: assert property (!key_fire && !(wr_take && apb_req_i.paddr == `WDT_CTRL_OFS) |=> $stable(wdt_ctrl_r))
    else $error("control changed without write");
  count_step_a: assert property (wd_tick && wdt_en && !cnt_clear && !overflow |=>
                                 cnt_r == $past(cnt_r) + `CNT_W'(1))
    else $error("enabled counter did not step");
  flag_clear_a: assert property (wr_take && !key_fire && apb_req_i.paddr == `RST_FLAG_OFS &&
                                 !apb_req_i.pwdata[`KEYFLAG_BIT] |=> !key_flag_r)
    else $error("key corruption flag not cleared by written 0");
  pdf_clear_a: assert property (clr_cmd && !halt_cmd |=> !power_down_flag_o)
    else $error("clear instruction left power-down set");
  sleep_pulse_a: assert property (pc_sp_clear_o |=> !pc_sp_clear_o)
    else $error("PC and SP clear longer than one cycle");
  ready_answer_a: assert property ((apb_req_i.psel && !apb_req_i.penable) ##1
                                   (apb_req_i.psel && apb_req_i.penable) |=> pready_o)
    else $error("bus answer not after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("bus ready longer than one cycle");
  error_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("bus error without ready");
  unmapped_error_a: assert property ((apb_req_i.psel && !apb_req_i.penable) ##1
                                     (apb_req_i.psel && apb_req_i.penable && !addr_ok) |=> pslverr_o)
    else $error("unmapped address not refused");

  // Main scenarios the bench should reach
  cover_normal_c: cover property (overflow && !sleep);
  cover_sleep_c:  cover property (overflow && sleep);
  cover_key_c:    cover property (key_fire);
  cover_irq_c:    cover property (irq_o);
  cover_clear_c:  cover property (key_flag_r ##1 !key_flag_r);
endmodule

// File: logic/wdt_params.svh
// Register map, field positions, reset values and keys of the watchdog timer
// What this block does
// - The watchdog clock is the low-speed crystal or the low-speed RC oscillator, picked by the source select bit.
// - The period field picks a time-out of 2^8, 2^10, 2^12, 2^14 or 2^15 to 2^18 watchdog clocks.
// - Key 10101B stops the watchdog and key 01010B runs it.
// - Any other key value resets the controller 2 to 3 RC oscillator cycles later.
// - A key-corruption reset sets bit 0 of the reset cause flags.
// - That flag is cleared only by software writing 0 to it, never by hardware.
// - After power-on the key field holds 01010B and the period field holds 011.
// - An overflow in normal operation resets the whole device and sets the time-out flag.
// - An overflow in sleep or idle sets the time-out flag and clears only program counter and stack pointer.
// - The counter clears on a key-corruption reset, the clear instruction, a halt or a low reset pin.
// - Bits 7 to 3 of the reset cause flags read as zero.
// - A halt clears the counter, which keeps counting when enabled and stays stopped when disabled.
// - A halt sets the power-down flag and clears the time-out flag.
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

`define WDT_CTRL_OFS  12'h000
`define RST_FLAG_OFS  12'h004
`define SYS_CLK_OFS   12'h008
`define CORE_STAT_OFS 12'h00C
`define IRQ_STAT_OFS  12'h010
`define IRQ_MASK_OFS  12'h014

`define WDT_CTRL_POR  8'h53
`define KEY_ENABLE    5'h0A
`define KEY_DISABLE   5'h15
`define KEY_MSB       7
`define KEY_LSB       3
`define PER_MSB       2
`define PER_LSB       0
`define KEYFLAG_BIT   0
`define FSS_BIT       0
`define TO_BIT        0
`define PDF_BIT       1
`define IRQ_TO_BIT    0
`define IRQ_KEY_BIT   1
`define IRQ_W         2

`define CNT_W         18
`define LAST_2P8      18'h000FF
`define LAST_2P10     18'h003FF
`define LAST_2P12     18'h00FFF
`define LAST_2P14     18'h03FFF
`define LAST_2P15     18'h07FFF
`define LAST_2P16     18'h0FFFF
`define LAST_2P17     18'h1FFFF
`define LAST_2P18     18'h3FFFF

`endif

// File: logic/wdt_pkg.sv
// Types shared by the watchdog timer and its bench
package wdt_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic clear_watchdog_instruction;
    logic halt_instruction;
    logic sleep_idle_mode;
  } core_cmd_t;

  typedef enum logic [1:0] {
    KEY_OK = 2'b00,
    KEY_W1 = 2'b01,
    KEY_W2 = 2'b11,
    KEY_W3 = 2'b10
  } key_state_t;
endpackage

// File: tb/core_model.sv
// Processor core model issuing clear and halt instructions
`timescale 1ns/1ns
module core_model #(
  parameter int GAP = 150
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          service_i,
  input  wire logic          halt_i,
  input  wire logic          sleep_i,
  output wdt_pkg::core_cmd_t cmd_o
);
  import wdt_pkg::*;
  int cnt;
  // Clear pulse every GAP cycles, far inside the shortest time-out
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt   <= 0;
      cmd_o <= '0;
    end else begin
      cnt                              <= (service_i && cnt < GAP - 1) ? cnt + 1 : 0;
      cmd_o.clear_watchdog_instruction <= service_i && cnt == GAP - 1;
      cmd_o.halt_instruction           <= halt_i;
      cmd_o.sleep_idle_mode            <= sleep_i;
    end
  end
endmodule

// File: tb/watchdog_timer_tb.sv
// Self-checking testbench of the keyed watchdog timer
`timescale 1ns/1ns
`include "wdt_params.svh"
module watchdog_timer_tb;
  import wdt_pkg::*;
  logic        clk_i, reset_n_i, rc, xt, pin_n, service, halt, sleep;
  logic        ready, err, mcu_rst, pcsp, to_f, pdf_f, irq;
  logic [31:0] rdata, rd;
  apb_req_t    req;
  core_cmd_t   cmd;
  int          bad_count, compares, resets, n, m, div;

  watchdog_timer watchdog_timer_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .apb_req_i(req), .pready_o(ready),
    .prdata_o(rdata), .pslverr_o(err), .core_cmd_i(cmd), .low_speed_crystal_osc_i(xt),
    .low_speed_internal_rc_osc_i(rc), .external_reset_pin_n_i(pin_n), .mcu_reset_o(mcu_rst),
    .pc_sp_clear_o(pcsp), .timeout_status_flag_o(to_f), .power_down_flag_o(pdf_f), .irq_o(irq));
  core_model core_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .service_i(service), .halt_i(halt),
    .sleep_i(sleep), .cmd_o(cmd));

  // System clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Slow clocks (RC period 4 cycles, crystal 6) and full reset counter
  always @(posedge clk_i) begin
    div    <= div + 1;
    rc     <= div[1];
    xt     <= (div % 6) >= 3;
    resets <= resets + 32'(mcu_rst === 1'b1);
  end

  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic e);
    int k;
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk_i);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      $display("[FAIL] bus ready expected 1 seen 0");
      tally_and_finish();
    end
    rd = rdata;
    e = err;
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
    check("write error", 32'h0, 32'(e));
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    check(nm, exp, rd);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic pulse_halt();
    @(posedge clk_i);
    halt <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
  endtask

  // Count edges until a full reset (pc low) or a PC/SP clear (pc high)
  task automatic wait_evt(input bit pc, input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((pc ? pcsp : mcu_rst) !== 1'b1 && n < lim);
    if (n >= lim) begin
      bad_count++;
      $display("[FAIL] reset pulse expected 1 seen 0");
      tally_and_finish();
    end
  endtask

  task automatic t_reset();
    logic e;
    rdc("control", `WDT_CTRL_OFS, 32'h53);
    rdc("reset flags", `RST_FLAG_OFS, 32'h0);
    apb(1'b0, 12'hFF0, 32'h0, e);
    check("unmapped error", 32'h1, 32'(e));
    check("unmapped data", 32'h0, rd);
    apb(1'b1, 12'hFF0, 32'hFF, e);
    check("unmapped write error", 32'h1, 32'(e));
    $display("test reset values done");
  endtask

  task automatic t_overflow();
    wr(`IRQ_MASK_OFS, 32'h3);
    rdc("irq mask", `IRQ_MASK_OFS, 32'h3);
    for (int p = 0; p < 3; p++) begin
      wr(`WDT_CTRL_OFS, 32'h50 | p);
      pulse_halt();
      m = 4 << (8 + 2 * p);
      wait_evt(1'b0, m + 100);
      check("overflow cycles", 32'h1, 32'(n > m - 12 && n < m + 12));
      idle(2);
      check("time-out flag", 32'h1, 32'(to_f));
      check("irq raised", 32'h1, 32'(irq));
      wr(`IRQ_STAT_OFS, 32'h1);
      idle(2);
      check("irq cleared", 32'h0, 32'(irq));
    end
    $display("test overflow done");
  endtask

  task automatic t_sleep();
    sleep <= 1'b1;
    wr(`WDT_CTRL_OFS, 32'h50);
    pulse_halt();
    idle(2);
    check("power-down", 32'h1, 32'(pdf_f));
    check("time-out cleared", 32'h0, 32'(to_f));
    rdc("core status", `CORE_STAT_OFS, 32'h2);
    m = resets;
    wait_evt(1'b1, 1100);
    idle(2);
    check("sleep time-out", 32'h1, 32'(to_f));
    check("no full reset", 32'(m), 32'(resets));
    sleep <= 1'b0;
    $display("test sleep done");
  endtask

  task automatic t_disable();
    m = resets;
    wr(`WDT_CTRL_OFS, 32'hA8);
    pulse_halt();
    idle(1500);
    check("disabled resets", 32'(m), 32'(resets));
    check("disabled time-out", 32'h0, 32'(to_f));
    $display("test disable done");
  endtask

  task automatic t_service();
    m = resets;
    wr(`WDT_CTRL_OFS, 32'h50);
    service <= 1'b1;
    idle(3000);
    service <= 1'b0;
    pin_n <= 1'b0;
    idle(1500);
    pin_n <= 1'b1;
    check("serviced resets", 32'(m), 32'(resets));
    check("clear drops power-down", 32'h0, 32'(pdf_f));
    $display("test service done");
  endtask

  task automatic t_crystal();
    wr(`SYS_CLK_OFS, 32'h1);
    rdc("clock select", `SYS_CLK_OFS, 32'h1);
    pulse_halt();
    wait_evt(1'b0, 3000);
    check("crystal cycles", 32'h1, 32'(n > 1524 && n < 1548));
    wr(`SYS_CLK_OFS, 32'h0);
    $display("test crystal done");
  endtask

  task automatic t_badkey();
    wr(`IRQ_STAT_OFS, 32'h3);
    wr(`WDT_CTRL_OFS, 32'h00);
    wait_evt(1'b0, 20);
    check("key delay", 32'h1, 32'(n >= 8 && n <= 18));
    rdc("key flag", `RST_FLAG_OFS, 32'h1);
    rdc("control reloaded", `WDT_CTRL_OFS, 32'h53);
    rdc("irq key bit", `IRQ_STAT_OFS, 32'h2);
    wr(`RST_FLAG_OFS, 32'h1);
    rdc("flag kept", `RST_FLAG_OFS, 32'h1);
    wr(`RST_FLAG_OFS, 32'h0);
    rdc("flag cleared", `RST_FLAG_OFS, 32'h0);
    $display("test bad key done");
  endtask

  // Main sequence
  initial begin
    req = '0;
    rc = 1'b0;
    xt = 1'b0;
    div = 0;
    pin_n = 1'b1;
    service = 1'b0;
    halt = 1'b0;
    sleep = 1'b0;
    bad_count = 0;
    compares = 0;
    resets = 0;
    reset_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_overflow();
    t_sleep();
    t_disable();
    t_service();
    t_crystal();
    t_badkey();
    tally_and_finish();
  end
endmodule
